// ---- design/preload_pkg.sv ----
package preload_pkg;

    // Register word offsets on the bus (byte addresses).
    localparam logic [7:0] ADDR_CMD     = 8'h00;
    localparam logic [7:0] ADDR_OP_PRE  = 8'h04;
    localparam logic [7:0] ADDR_OP_ACT  = 8'h08;
    localparam logic [7:0] ADDR_CMP_PRE = 8'h0C;
    localparam logic [7:0] ADDR_CMP_ACT = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_CTRL    = 8'h18;

    // Command codes written to the command register.
    localparam logic [15:0] CMD_CANCEL_OP_QUEUE      = 16'h0026;
    localparam logic [15:0] CMD_CANCEL_CMP_PRELOAD   = 16'h0027;
    localparam logic [15:0] CMD_RESET_CMP_STATE      = 16'h002D;
    localparam logic [15:0] CMD_IMMEDIATE_STOP       = 16'h0049;
    localparam logic [15:0] CMD_DECELERATE_STOP      = 16'h004A;
    localparam logic [15:0] CMD_START_LOW_SPEED      = 16'h0050;
    localparam logic [15:0] CMD_START_HIGH_SPEED     = 16'h0051;
    localparam logic [15:0] CMD_START_HS_RAMPED      = 16'h0052;
    localparam logic [15:0] CMD_START_ACCEL_DECEL    = 16'h0053;
    localparam logic [15:0] CMD_NEXT_LOW_SPEED       = 16'h0054;
    localparam logic [15:0] CMD_NEXT_HIGH_SPEED      = 16'h0055;
    localparam logic [15:0] CMD_NEXT_RAMPED          = 16'h0056;
    localparam logic [15:0] CMD_NEXT_ACCEL_DECEL     = 16'h0057;

    // Status register field positions.
    localparam int ST_OP_STATE_LSB  = 0;
    localparam int ST_CMP_STATE_LSB = 2;
    localparam int ST_OP_FULL       = 4;
    localparam int ST_CMP_FULL      = 5;
    localparam int ST_MOVING        = 6;

    // Control register field positions.
    localparam int CTL_QADV_IRQ_EN  = 0;
    localparam int CTL_CMP3_IRQ_EN  = 1;
    localparam int CTL_COMPL_TIMING = 2;

    // Queue fill encodings and reset values.
    localparam logic [1:0]  Q_NONE      = 2'h0;
    localparam logic [1:0]  Q_ACTIVE    = 2'h1;
    localparam logic [1:0]  Q_BOTH      = 2'h2;
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [2:0]  RESET_CTRL  = 3'h0;

    // Classic Wishbone request and answer bundles.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Events toward the network master, one-cycle pulses.
    typedef struct packed {
        logic queue_advance;
        logic next_start_error;
        logic compare3_hit;
    } evt_t;

endpackage

// ---- design/level_edge_detect.sv ----
`timescale 1ns/1ps
module level_edge_detect (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    logic last_r;

    // The level comes from logic on the same clock, so no synchroniser is needed.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            last_r <= 1'b0;
        else
            last_r <= level;
    end

    assign rise = level & ~last_r;
    assign fall = ~level & last_r;
endmodule

// ---- design/operation_preload_buffer.sv ----
`timescale 1ns/1ps
// Contract
// - Reset clears every register and both preload stages to zero.
// - Unused bits ignore writes and read as zero.
// - Sign-extension bits ignore writes and read the top data bit.
// - Writes while stopped land in the active stage; while moving, preload only.
// - Operation data is fixed only by a start or next-start command.
// - Motion done with fixed preload shifts it active and restarts motion.
// - Op queue state reads 00, 01, 10; full flag set at 10.
// - Preload writes are refused while both operation stages are fixed.
// - Direct writes to the active stage override the running motion.
// - Queue-advance event fires on fixed-to-unfixed shift when enabled.
// - Next-start while stopped raises error event and starts nothing.
// - Immediate stop and decelerate stop clear op queue to 00; so does cancel unless both are fixed.
// - Cancel with both fixed drops only preload; state becomes 01.
// - Error stop discards op queue and returns state 00.
// - Compare active write loads directly; preload write queues or lands active.
// - Compare data is writable whether stopped or moving.
// - Compare data is fixed by the write itself.
// - Compare true-then-false advances preload, or unfixes active if empty.
// - Compare state reads 00, 01, 10; at 10 full flag set, preload writes refused.
// - Compare3 event fires on each true edge when enabled.
// - Compare cancel drops preload keeping active; compare reset returns 00.
module operation_preload_buffer #(
    parameter int OP_W  = 28,
    parameter int CMP_W = 28
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire preload_pkg::wb_req_t wb_req,
    output preload_pkg::wb_rsp_t      wb_rsp,
    input  wire logic                 motion_done,
    input  wire logic                 error_stop,
    input  wire logic                 compare3_match,
    output logic                      motion_start,
    output logic                      motion_stop,
    output logic                      moving,
    output logic [OP_W-1:0]           op_active,
    output logic [CMP_W-1:0]          compare3_active,
    output logic                      completion_timing_sel,
    output logic                      op_queue_full_flag,
    output logic                      compare_queue_full_flag,
    output preload_pkg::evt_t         events
);
    import preload_pkg::*;

    // Bus handshake state.
    logic              ack_r;
    logic [31:0]       rdat_r;

    // Operation queue.
    logic [OP_W-1:0]   op_pre_r;
    logic [OP_W-1:0]   op_act_r;
    logic [1:0]        op_queue_state_r;
    logic [1:0]        op_queue_state_nxt;
    logic              moving_r;
    logic              moving_nxt;

    // Compare queue.
    logic [CMP_W-1:0]  cmp_pre_r;
    logic [CMP_W-1:0]  cmp_act_r;
    logic [1:0]        compare_queue_state_r;
    logic [1:0]        compare_queue_state_nxt;

    // Control and event pulses.
    logic [2:0]        ctrl_r;
    logic              start_pulse_r;
    logic              stop_pulse_r;
    logic              qadv_evt_r;
    logic              err_evt_r;
    logic              cmp_evt_r;

    // Read path.
    logic [31:0]       read_word;
    logic [31:0]       status_word;

    // Request decoding. A write takes effect on the edge the master samples ack.
    // A partial sel write is acked but changes nothing.
    // Unaligned addresses match no register.
    wire access_new  = wb_req.cyc & wb_req.stb & ~ack_r;
    wire wr_commit   = wb_req.cyc & wb_req.stb & wb_req.we & ack_r & (&wb_req.sel);
    wire hit_cmd     = (wb_req.adr == ADDR_CMD);
    wire hit_op_pre  = (wb_req.adr == ADDR_OP_PRE);
    wire hit_op_act  = (wb_req.adr == ADDR_OP_ACT);
    wire hit_cmp_pre = (wb_req.adr == ADDR_CMP_PRE);
    wire hit_cmp_act = (wb_req.adr == ADDR_CMP_ACT);
    wire hit_ctrl    = (wb_req.adr == ADDR_CTRL);
    wire [15:0] code = wb_req.dat[15:0];

    // Unknown codes are acked and ignored.
    // Starts and next-starts come in four speed kinds.
    wire cmd_wr      = wr_commit & hit_cmd;
    wire cmd_start   = cmd_wr & ((code == CMD_START_LOW_SPEED)
                               | (code == CMD_START_HIGH_SPEED)
                               | (code == CMD_START_HS_RAMPED)
                               | (code == CMD_START_ACCEL_DECEL));
    wire cmd_next    = cmd_wr & ((code == CMD_NEXT_LOW_SPEED)
                               | (code == CMD_NEXT_HIGH_SPEED)
                               | (code == CMD_NEXT_RAMPED)
                               | (code == CMD_NEXT_ACCEL_DECEL));
    wire cmd_cancel  = cmd_wr & (code == CMD_CANCEL_OP_QUEUE);
    wire cmd_stop    = cmd_wr & ((code == CMD_IMMEDIATE_STOP)
                               | (code == CMD_DECELERATE_STOP));
    wire cmd_cmp_can = cmd_wr & (code == CMD_CANCEL_CMP_PRELOAD);
    wire cmd_cmp_rst = cmd_wr & (code == CMD_RESET_CMP_STATE);

    // Preload writes are dropped once both stages hold fixed data.
    wire op_pre_wr   = wr_commit & hit_op_pre & (op_queue_state_r != Q_BOTH);
    wire op_act_wr   = wr_commit & hit_op_act;
    // Compare writes are taken moving or stopped.
    wire cmp_pre_wr  = wr_commit & hit_cmp_pre
                     & (compare_queue_state_r != Q_BOTH);
    wire cmp_act_wr  = wr_commit & hit_cmp_act;

    // A start on a stopped axis begins motion; a next-start there is an error.
    wire go_now      = (cmd_start | cmd_next) & ~moving_r & ~cmd_next;
    wire next_err    = cmd_next & ~moving_r;
    // On a moving axis a start fixes the preload stage.
    wire fix_next    = (cmd_start | cmd_next) & moving_r
                     & (op_queue_state_r == Q_ACTIVE);
    wire flush_op    = cmd_stop | error_stop;
    // An error stop outranks a completion.
    wire op_done     = motion_done & moving_r;
    wire auto_shift  = op_done & (op_queue_state_r == Q_BOTH) & ~flush_op;

    // Compare edge detection for advancing the queue and raising events.
    logic cmp_rise;
    logic cmp_fall;

    // Resets low like the idle comparator: no false edge.
    level_edge_detect u_cmp_edge (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .level   (compare3_match),
        .rise    (cmp_rise),
        .fall    (cmp_fall)
    );

    // Operation queue state. Stops outrank everything so a stop is never lost.
    always_comb
    begin
        op_queue_state_nxt = op_queue_state_r;
        moving_nxt         = moving_r;
        if (flush_op)
        begin
            op_queue_state_nxt = Q_NONE;
            moving_nxt         = 1'b0;
        end
        // Cancel drops data only; stops and errors end motion.
        else if (cmd_cancel)
        begin
            op_queue_state_nxt = (op_queue_state_r == Q_BOTH) ? Q_ACTIVE : Q_NONE;
        end
        else if (auto_shift)
        begin
            op_queue_state_nxt = Q_ACTIVE;
        end
        // Done with nothing queued: the axis rests.
        else if (op_done)
        begin
            op_queue_state_nxt = Q_NONE;
            moving_nxt         = 1'b0;
        end
        else if (go_now)
        begin
            op_queue_state_nxt = Q_ACTIVE;
            moving_nxt         = 1'b1;
        end
        else if (fix_next)
        begin
            op_queue_state_nxt = Q_BOTH;
        end
    end

    // Compare queue state. Cancel and reset commands take priority over edges.
    // Writing alone fixes compare data; no start is involved.
    always_comb
    begin
        compare_queue_state_nxt = compare_queue_state_r;
        if (cmd_cmp_rst)
            compare_queue_state_nxt = Q_NONE;
        else if (cmd_cmp_can)
            compare_queue_state_nxt = (compare_queue_state_r == Q_NONE)
                                    ? Q_NONE : Q_ACTIVE;
        else if (cmp_pre_wr)
            compare_queue_state_nxt = (compare_queue_state_r == Q_NONE)
                                    ? Q_ACTIVE : Q_BOTH;
        else if (cmp_act_wr && compare_queue_state_r == Q_NONE)
            compare_queue_state_nxt = Q_ACTIVE;
        // A preload write or command beats a same-cycle fall; the fall is lost.
        else if (cmp_fall && compare_queue_state_r != Q_NONE)
            compare_queue_state_nxt = compare_queue_state_r - 2'h1;
    end

    // Bus answer: ack one cycle after the request, read data captured with it.
    // Ack lasts one cycle even if stb stays high; data is zero outside it.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_r  <= 1'b0;
            rdat_r <= RESET_WORD;
        end
        else
        begin
            ack_r  <= access_new;
            rdat_r <= access_new ? read_word : RESET_WORD;
        end
    end

    // Read multiplexer. Unmapped offsets and the command register read zero.
    // Reads have no side effects.
    // Status bits above moving read zero.

    assign status_word = {25'h0, moving_r,
                          (compare_queue_state_r == Q_BOTH),
                          (op_queue_state_r == Q_BOTH),
                          compare_queue_state_r, op_queue_state_r};
    assign read_word =
        hit_op_pre  ? {{(32-OP_W){op_pre_r[OP_W-1]}}, op_pre_r}       :
        hit_op_act  ? {{(32-OP_W){op_act_r[OP_W-1]}}, op_act_r}       :
        hit_cmp_pre ? {{(32-CMP_W){cmp_pre_r[CMP_W-1]}}, cmp_pre_r}   :
        hit_cmp_act ? {{(32-CMP_W){cmp_act_r[CMP_W-1]}}, cmp_act_r}   :
        (wb_req.adr == ADDR_STATUS) ? status_word                     :
        hit_ctrl    ? {29'h0, ctrl_r}                                 :
        RESET_WORD;

    // Operation data path. While stopped a preload write reaches both stages at once,
    // so a start can fix it without another copy.
    // An override beats an automatic shift in the same cycle.
    // A consumed preload keeps its value, which reads back.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            op_pre_r <= '0;
            op_act_r <= '0;
        end
        else
        begin
            if (op_pre_wr)
                op_pre_r <= wb_req.dat[OP_W-1:0];
            if (op_act_wr)
                op_act_r <= wb_req.dat[OP_W-1:0];
            else if (op_pre_wr && !moving_r)
                op_act_r <= wb_req.dat[OP_W-1:0];
            else if (auto_shift)
                op_act_r <= op_pre_r;
        end
    end

    // Compare data path. Accepted moving or not; preload writes are refused while both stages are fixed.
    // Preload moves to active only when both stages are fixed.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmp_pre_r <= '0;
            cmp_act_r <= '0;
        end
        else
        begin
            if (cmp_pre_wr)
                cmp_pre_r <= wb_req.dat[CMP_W-1:0];
            if (cmp_act_wr)
                cmp_act_r <= wb_req.dat[CMP_W-1:0];
            else if (cmp_pre_wr && compare_queue_state_r == Q_NONE)
                cmp_act_r <= wb_req.dat[CMP_W-1:0];
            else if (cmp_fall && compare_queue_state_r == Q_BOTH && !cmd_cmp_can
                     && !cmd_cmp_rst)
                cmp_act_r <= cmp_pre_r;
        end
    end

    // Queue states and motion flag.
    // They change on the same edge as the data they describe.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            op_queue_state_r      <= Q_NONE;
            compare_queue_state_r <= Q_NONE;
            moving_r              <= 1'b0;
        end
        else
        begin
            op_queue_state_r      <= op_queue_state_nxt;
            compare_queue_state_r <= compare_queue_state_nxt;
            moving_r              <= moving_nxt;
        end
    end

    // Control bits: event enables and completion timing, passed to the pulse
    // generator. Chained motions want pulse-cycle completion, value zero.
    // Only the low three bits are kept; the rest read zero.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ctrl_r <= RESET_CTRL;
        else if (wr_commit && hit_ctrl)
            ctrl_r <= wb_req.dat[2:0];
    end

    // One-cycle pulses for the pulse generator and the master's event line.
    // Enables gate the advance and compare events, never the queue actions; the error event is ungated.
    // A start lost to a same-cycle error stop gives no pulse.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            start_pulse_r <= 1'b0;
            stop_pulse_r  <= 1'b0;
            qadv_evt_r    <= 1'b0;
            err_evt_r     <= 1'b0;
            cmp_evt_r     <= 1'b0;
        end
        else
        begin
            start_pulse_r <= (go_now & ~flush_op) | auto_shift;
            stop_pulse_r  <= cmd_stop;
            qadv_evt_r    <= auto_shift & ctrl_r[CTL_QADV_IRQ_EN];
            err_evt_r     <= next_err;
            cmp_evt_r     <= cmp_rise & ctrl_r[CTL_CMP3_IRQ_EN];
        end
    end

    // Outputs.
    // Full flags decode the registered states.
    assign wb_rsp.ack              = ack_r;
    assign wb_rsp.dat              = rdat_r;
    assign motion_start            = start_pulse_r;
    assign motion_stop             = stop_pulse_r;
    assign moving                  = moving_r;
    assign op_active               = op_act_r;
    assign compare3_active         = cmp_act_r;
    assign completion_timing_sel   = ctrl_r[CTL_COMPL_TIMING];
    assign op_queue_full_flag      = (op_queue_state_r == Q_BOTH);
    assign compare_queue_full_flag = (compare_queue_state_r == Q_BOTH);
    assign events.queue_advance    = qadv_evt_r;
    assign events.next_start_error = err_evt_r;
    assign events.compare3_hit     = cmp_evt_r;
endmodule

// ---- sim/motion_gen_model.sv ----
`timescale 1ns/1ps
// Stand-in pulse generator: ends each motion DUR cycles after it starts.
module motion_gen_model #(
    parameter int DUR = 40
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic motion_start,
    input  wire logic moving,
    input  wire logic allow,
    output logic      motion_done
);
    int cnt;

    // The bench holds allow low to stall completion while it fills the queue.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt         <= 0;
            motion_done <= 1'h0;
        end
        else
        begin
            motion_done <= (cnt == 1) && allow && moving && !motion_start && !motion_done;
            if (motion_start)
                cnt <= DUR;
            else if (!moving || motion_done)
                cnt <= 0;
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
    end
endmodule

// ---- sim/preload_buffer_chk.sv ----
`timescale 1ns/1ps
// Port-level checks; each ties an output to an input event or to another output.
module preload_buffer_chk
    import preload_pkg::*;
#(
    parameter int OP_W  = 28,
    parameter int CMP_W = 28
) (
    input wire logic                 sys_clk,
    input wire logic                 rstn,
    input wire preload_pkg::wb_req_t wb_req,
    input wire preload_pkg::wb_rsp_t wb_rsp,
    input wire logic                 motion_done,
    input wire logic                 error_stop,
    input wire logic                 compare3_match,
    input wire logic                 motion_start,
    input wire logic                 motion_stop,
    input wire logic                 moving,
    input wire logic [OP_W-1:0]      op_active,
    input wire logic [CMP_W-1:0]     compare3_active,
    input wire logic                 completion_timing_sel,
    input wire logic                 op_queue_full_flag,
    input wire logic                 compare_queue_full_flag,
    input wire preload_pkg::evt_t    events
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Bus handshake: one registered ack, data only while it stands.
    ack_answer_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("ack missing one cycle after request");
    ack_single_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    rdata_idle_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
        else $error("read data not zero outside ack");
    // Queue behaviour seen at the motion side.
    reset_clear_a: assert property ($rose(rstn) |-> op_active == '0 && !moving && !events)
        else $error("outputs not cleared by reset");
    start_moving_a: assert property (motion_start |-> moving)
        else $error("motion start without moving");
    auto_advance_a: assert property (
        motion_done && op_queue_full_flag && !error_stop |=> motion_start)
        else $error("no automatic start from fixed preload");
    full_moving_a: assert property (op_queue_full_flag |-> moving)
        else $error("operation queue full while stopped");
    advance_event_a: assert property (events.queue_advance |-> motion_start)
        else $error("queue advance event without shift");
    next_error_a: assert property (events.next_start_error |-> !moving && !motion_start)
        else $error("next start error with motion");
    stop_clear_a: assert property (motion_stop |-> !moving && !op_queue_full_flag)
        else $error("stop left motion or queue");
    error_clear_a: assert property (error_stop |=> !moving && !op_queue_full_flag)
        else $error("error stop left motion or queue");
    compare_advance_a: assert property ($fell(compare3_match) && compare_queue_full_flag
        |-> ##[1:3] !compare_queue_full_flag)
        else $error("compare queue did not advance");
    hit_cause_a: assert property (events.compare3_hit
        |-> $past(compare3_match) || $past(compare3_match, 2))
        else $error("compare event without match");

    cover property (events.queue_advance);
    cover property (events.next_start_error);
    cover property (events.compare3_hit);
endmodule

bind operation_preload_buffer preload_buffer_chk #(.OP_W(OP_W), .CMP_W(CMP_W)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .motion_done(motion_done), .error_stop(error_stop), .compare3_match(compare3_match),
    .motion_start(motion_start), .motion_stop(motion_stop), .moving(moving),
    .op_active(op_active), .compare3_active(compare3_active),
    .completion_timing_sel(completion_timing_sel), .op_queue_full_flag(op_queue_full_flag),
    .compare_queue_full_flag(compare_queue_full_flag), .events(events)
);

// ---- sim/operation_preload_buffer_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got %0h expected %0h", $time, (g), (e)); end end
module operation_preload_buffer_bench;
    import preload_pkg::*;
    localparam int LIMIT = 6000;
    logic        sys_clk = 1'h0;
    logic        rstn, motion_done, error_stop, compare3_match, allow;
    logic        motion_start, motion_stop, moving, completion_timing_sel;
    logic        op_queue_full_flag, compare_queue_full_flag;
    logic [27:0] op_active, compare3_active;
    logic [31:0] q;
    logic [15:0] stops [4] = '{CMD_IMMEDIATE_STOP, CMD_DECELERATE_STOP, CMD_IMMEDIATE_STOP, 16'h0};
    wb_req_t     wb_req;
    wb_rsp_t     wb_rsp;
    evt_t        events;
    int          errors, checks, cycles, n_start, n_qadv, n_err, n_hit, s;

    operation_preload_buffer u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .motion_done(motion_done), .error_stop(error_stop),
        .compare3_match(compare3_match), .motion_start(motion_start),
        .motion_stop(motion_stop), .moving(moving), .op_active(op_active),
        .compare3_active(compare3_active), .completion_timing_sel(completion_timing_sel),
        .op_queue_full_flag(op_queue_full_flag),
        .compare_queue_full_flag(compare_queue_full_flag), .events(events));
    motion_gen_model u_gen (.sys_clk(sys_clk), .rstn(rstn), .motion_start(motion_start),
        .moving(moving), .allow(allow), .motion_done(motion_done));

    always #2.5 sys_clk = ~sys_clk;

    // Event counters lag one cycle, so waits leave slack before comparing them.
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        n_start <= n_start + int'(motion_start === 1'h1);
        n_qadv <= n_qadv + int'(events.queue_advance === 1'h1);
        n_err <= n_err + int'(events.next_start_error === 1'h1);
        n_hit <= n_hit + int'(events.compare3_hit === 1'h1);
        if (cycles == LIMIT)
        begin
            errors++;
            print_verdict();
        end
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'hF, dat: d};
        @(posedge sys_clk);
        while (wb_rsp.ack !== 1'h1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        errors += int'(n == 50);
        q = wb_rsp.dat;
        wb_req <= '0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask

    task automatic cmd(input logic [15:0] c);
        xfer(1'h1, ADDR_CMD, {16'h0, c});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        `CHK(q, e);
    endtask

    // Match held several cycles so both edges are seen apart.
    task automatic pulse_match;
        compare3_match <= 1'h1;
        repeat (4) @(posedge sys_clk);
        compare3_match <= 1'h0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (moving !== 1'h0 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        repeat (2) @(posedge sys_clk);
    endtask

    task print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: reset, register bits, operation queue, stops, compare queue.
    initial
    begin
        {rstn, error_stop, compare3_match, allow} = 4'h0;
        wb_req = '0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'h1;
        @(posedge sys_clk);
        `CHK(op_active, 28'h0);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_CMP_ACT, 32'h0);
        wr(ADDR_OP_ACT, 32'h0800_0001);
        rd(ADDR_OP_ACT, 32'hF800_0001);
        wr(ADDR_OP_ACT, 32'h7000_0005);
        rd(ADDR_OP_ACT, 32'h5);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_CTRL, 32'hFFFF_FFF9);
        rd(ADDR_CTRL, 32'h1);
        `CHK(completion_timing_sel, 1'h0);
        rd(8'h1C, 32'h0);
        wr(ADDR_OP_PRE, 32'h111);
        rd(ADDR_OP_ACT, 32'h111);
        rd(ADDR_STATUS, 32'h0);
        cmd(CMD_START_LOW_SPEED);
        rd(ADDR_STATUS, 32'h41);
        wr(ADDR_OP_PRE, 32'h222);
        rd(ADDR_OP_ACT, 32'h111);
        cmd(CMD_NEXT_HIGH_SPEED);
        rd(ADDR_STATUS, 32'h52);
        `CHK(op_queue_full_flag, 1'h1);
        wr(ADDR_OP_PRE, 32'h333);
        rd(ADDR_OP_PRE, 32'h222);
        allow <= 1'h1;
        wait_idle();
        `CHK(n_start, 2);
        `CHK(n_qadv, 1);
        `CHK(op_active, 28'h222);
        rd(ADDR_STATUS, 32'h0);
        allow <= 1'h0;
        for (int k = 0; k < 4; k++)
        begin
            cmd(CMD_START_LOW_SPEED + 16'(k));
            wr(ADDR_OP_PRE, 32'h5);
            cmd(CMD_NEXT_LOW_SPEED + 16'(k));
            rd(ADDR_STATUS, (k > 1) ? 32'h56 : 32'h52);
            if (k == 0)
            begin
                cmd(CMD_CANCEL_OP_QUEUE);
                rd(ADDR_STATUS, 32'h41);
                cmd(CMD_CANCEL_OP_QUEUE);
                rd(ADDR_STATUS, 32'h40);
            end
            if (k == 1)
            begin
                wr(ADDR_OP_ACT, 32'h444);
                `CHK(op_active, 28'h444);
                wr(ADDR_CMP_ACT, 32'h77);
                `CHK(compare3_active, 28'h77);
            end
            if (k == 3)
                error_stop <= 1'h1;
            else
                cmd(stops[k]);
            @(posedge sys_clk);
            error_stop <= 1'h0;
            rd(ADDR_STATUS, (k > 0) ? 32'h4 : 32'h0);
        end
        s = n_start;
        for (int k = 0; k < 4; k++)
            cmd(CMD_NEXT_LOW_SPEED + 16'(k));
        wait_idle();
        `CHK(n_err, 4);
        `CHK(n_start, s);
        cmd(CMD_RESET_CMP_STATE);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_CMP_PRE, 32'hA);
        rd(ADDR_CMP_ACT, 32'hA);
        wr(ADDR_CMP_PRE, 32'hB);
        rd(ADDR_STATUS, 32'h28);
        `CHK(compare_queue_full_flag, 1'h1);
        wr(ADDR_CMP_PRE, 32'hC);
        rd(ADDR_CMP_PRE, 32'hB);
        pulse_match();
        `CHK(n_hit, 1);
        rd(ADDR_CMP_ACT, 32'hB);
        rd(ADDR_STATUS, 32'h4);
        pulse_match();
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_CMP_PRE, 32'hE);
        wr(ADDR_CMP_PRE, 32'hF);
        cmd(CMD_CANCEL_CMP_PRELOAD);
        rd(ADDR_STATUS, 32'h4);
        cmd(CMD_RESET_CMP_STATE);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_CMP_ACT, 32'h0800_0000);
        `CHK(compare3_active, 28'h800_0000);
        print_verdict();
    end
endmodule
